// File: design/exc_sup_defines.svh
// Offsets, field positions, reset values and timing counts of the field supervision block
`ifndef EXC_SUP_DEFINES_SVH
`define EXC_SUP_DEFINES_SVH

// Timing
`define CLK_PERIOD_NS   10
`define TICK_PERIOD_NS  5000000
`define TICK_CYCLES     (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_MS         5
`define BRK_STEP_MS     100
`define BRK_STEP_TICKS  (`BRK_STEP_MS / `TICK_MS)

// Register offsets
`define ADDR_CTRL       4'h0
`define ADDR_OF_DELAY   4'h1
`define ADDR_CTRL_HI    4'h2
`define ADDR_IFLD_LO    4'h3
`define ADDR_TEMP_LVL   4'h4
`define ADDR_BRK_TIME   4'h5
`define ADDR_INV_TIME   4'h6
`define ADDR_RAMP_RATE  4'h7
`define ADDR_STATUS     4'h8
`define ADDR_CTRL_OUT   4'h9

// Control fields
`define CTRL_OF_EN      0
`define CTRL_INT_TRIP   1
`define CTRL_FORCE      2

// Status fields
`define STS_OF_TRIP     0
`define STS_TEMP_ALARM  1
`define STS_BRK_FAIL    2
`define STS_RUNDOWN     3
`define STS_BRK_TRIP    4

// Reset values
`define CTRL_RST        16'h0000
`define OF_DELAY_RST    16'h0258
`define CTRL_HI_RST     16'h0064
`define IFLD_LO_RST     16'h000A
`define TEMP_LVL_RST    16'h0064
`define BRK_TIME_RST    16'h0005
`define INV_TIME_RST    16'h000A
`define RAMP_RATE_RST   16'h0014

// Ramp: one control LSB of 0.01 p.u. equals 2000 units of rate (0.001 p.u./s) times one tick
`define RAMP_FRAC_ONE   17'h007D0
`define CTRL_MAX        16'h09C4

`endif

// File: design/exc_sup_pkg.sv
// Types shared by the field supervision design
package exc_sup_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        BRK_IDLE,
        BRK_RUNDOWN,
        BRK_TRIP_WAIT,
        BRK_OPENED
    } brk_state_t;
endpackage : exc_sup_pkg

// File: design/sup_delay_timer.sv
// Tick counting delay timer that restarts whenever its condition drops
`timescale 1ns/1ps
module sup_delay_timer #(
    parameter int CW = 24
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    // Timing
    input  wire logic          tick,
    input  wire logic          run,
    input  wire logic [CW-1:0] limit,
    // Result
    output logic               expired_q
);
    logic [CW-1:0] count_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_q   <= '0;
            expired_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                count_q   <= '0; // R13
                expired_q <= 1'b0;
            end else begin
                if (tick && count_q < limit) begin
                    count_q <= count_q + 1'b1;
                end
                expired_q <= (count_q >= limit);
            end
        end
    end

    timer_restart_a: assert property (@(posedge clk) disable iff (!rst_b) // R13
        (ce && !run) |=> (count_q == '0 && !expired_q))
        else $error("timer did not restart when its condition dropped");
endmodule : sup_delay_timer

// File: design/excitation_field_supervision.sv
// Open field, switch temperature, field breaker trip and open loop ramp supervision
// Functional notes
// (R1) Open field monitoring has an enable, off after reset; no open field trip while off.
// (R2) Open field means control signal above high threshold and field current not above low.
// (R3) Enabled open field lasting the detection delay trips the rectifier and stops excitation.
// (R4) Open field delay counts in 5 ms steps, default 3.000 s.
// (R5) Control signal high threshold in 0.01 steps, default 1.00.
// (R6) Field current low threshold in 0.01 steps, default 0.10, equal counts as low.
// (R7) Switch temperature above a settable level, default 100, always raises an alarm.
// (R8) With internal trip enabled and circuit open, breaker off runs excitation down, then trips.
// (R9) Breaker not open within the trip time after the trip command gives an event.
// (R10) Breaker trip supervision time in 0.1 s steps, default 0.5 s.
// (R11) Inverter mode stopping time before the breaker opens defaults to 1.0 s.
// (R12) Open loop forcing ramps the control signal at the set rate, default 0.02 p.u./s.
// (R13) Each delay restarts from zero when its condition clears before expiry.
`timescale 1ns/1ps
`include "exc_sup_defines.svh"
module excitation_field_supervision
    import exc_sup_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata_q,
    // Measurements, 0.01 p.u. per count, temperature in degrees
    input  wire logic [15:0] ctrl_in,
    input  wire logic [15:0] ifield_in,
    input  wire logic [15:0] temp_in,
    // Open loop ramp commands
    input  wire logic        ramp_up,
    input  wire logic        ramp_down,
    // Field breaker side
    input  wire logic        mcc_open,
    input  wire logic        brk_off_cmd,
    input  wire logic        brk_open,
    // Supervision outputs
    output logic             rect_trip_q,
    output logic             exc_stop_q,
    output logic             rundown_q,
    output logic             brk_trip_q,
    output logic             brk_fail_evt_q,
    output logic             temp_alarm_q,
    output logic      [15:0] ctrl_out_q
);
    localparam int TW = 24;

    word_t      ctrl_q;
    word_t      of_delay_q;
    word_t      ctrl_hi_q;
    word_t      ifld_lo_q;
    word_t      temp_lvl_q;
    word_t      brk_time_q;
    word_t      inv_time_q;
    word_t      ramp_rate_q;
    logic       brk_fail_sts_q;
    logic       fail_done_q;
    logic [31:0] presc_q;
    logic       tick_q;
    logic [16:0] frac_q;
    brk_state_t st_q;
    brk_state_t st_d;
    logic [2:0]  t_run;
    logic [2:0]  t_exp;
    logic [TW-1:0] t_lim [3];
    logic        cfg_wr;
    logic [15:0] sts_clr;
    logic        of_en;
    logic        int_trip_en;
    logic        forcing;
    logic        of_cond;
    logic [16:0] frac_sum;

    assign cfg_wr      = ce && wr;
    assign sts_clr     = (cfg_wr && addr == `ADDR_STATUS) ? wdata : 16'h0000;
    assign of_en       = ctrl_q[`CTRL_OF_EN];
    assign int_trip_en = ctrl_q[`CTRL_INT_TRIP];
    assign forcing     = ctrl_q[`CTRL_FORCE];

    // Configuration registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q      <= `CTRL_RST; // R1
            of_delay_q  <= `OF_DELAY_RST; // R4
            ctrl_hi_q   <= `CTRL_HI_RST; // R5
            ifld_lo_q   <= `IFLD_LO_RST; // R6
            temp_lvl_q  <= `TEMP_LVL_RST; // R7
            brk_time_q  <= `BRK_TIME_RST; // R10
            inv_time_q  <= `INV_TIME_RST; // R11
            ramp_rate_q <= `RAMP_RATE_RST; // R12
        end else if (cfg_wr) begin
            case (addr)
                `ADDR_CTRL:      ctrl_q      <= wdata & 16'h0007;
                `ADDR_OF_DELAY:  of_delay_q  <= wdata;
                `ADDR_CTRL_HI:   ctrl_hi_q   <= wdata;
                `ADDR_IFLD_LO:   ifld_lo_q   <= wdata;
                `ADDR_TEMP_LVL:  temp_lvl_q  <= wdata;
                `ADDR_BRK_TIME:  brk_time_q  <= wdata;
                `ADDR_INV_TIME:  inv_time_q  <= wdata;
                `ADDR_RAMP_RATE: ramp_rate_q <= wdata;
                default: ;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 16'h0000;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    `ADDR_CTRL:      rdata_q <= ctrl_q;
                    `ADDR_OF_DELAY:  rdata_q <= of_delay_q;
                    `ADDR_CTRL_HI:   rdata_q <= ctrl_hi_q;
                    `ADDR_IFLD_LO:   rdata_q <= ifld_lo_q;
                    `ADDR_TEMP_LVL:  rdata_q <= temp_lvl_q;
                    `ADDR_BRK_TIME:  rdata_q <= brk_time_q;
                    `ADDR_INV_TIME:  rdata_q <= inv_time_q;
                    `ADDR_RAMP_RATE: rdata_q <= ramp_rate_q;
                    `ADDR_STATUS:    rdata_q <= {11'h000, brk_trip_q, rundown_q, brk_fail_sts_q,
                                                 temp_alarm_q, rect_trip_q};
                    `ADDR_CTRL_OUT:  rdata_q <= ctrl_out_q;
                    default:         rdata_q <= 16'h0000;
                endcase
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end

    // Time base of 5 ms ticks; shorten TICK_CYCLES in simulation
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            presc_q <= 32'h00000000;
            tick_q  <= 1'b0;
        end else if (ce) begin
            if (presc_q >= 32'(TICK_CYCLES - 1)) begin
                presc_q <= 32'h00000000;
                tick_q  <= 1'b1;
            end else begin
                presc_q <= presc_q + 32'h00000001;
                tick_q  <= 1'b0;
            end
        end
    end

    // Delay timers: open field, inverter stop, breaker supervision
    assign of_cond  = (ctrl_out_q > ctrl_hi_q) && (ifield_in <= ifld_lo_q); // R2
    assign t_run[0] = of_en && of_cond; // R3
    assign t_run[1] = (st_q == BRK_RUNDOWN); // R11
    assign t_run[2] = (st_q == BRK_TRIP_WAIT) && !brk_open; // R9
    assign t_lim[0] = {8'h00, of_delay_q}; // R4
    assign t_lim[1] = TW'(inv_time_q) * TW'(`BRK_STEP_TICKS); // R11
    assign t_lim[2] = TW'(brk_time_q) * TW'(`BRK_STEP_TICKS); // R10

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_timer
            sup_delay_timer #(
                .CW(TW)
            ) u_timer (
                .clk       (clk),
                .rst_b     (rst_b),
                .ce        (ce),
                .tick      (tick_q),
                .run       (t_run[gi]),
                .limit     (t_lim[gi]),
                .expired_q (t_exp[gi])
            );
        end
    endgenerate

    // Open field trip holds until cleared by software or monitoring disabled; set wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rect_trip_q <= 1'b0;
            exc_stop_q  <= 1'b0;
        end else if (ce) begin
            rect_trip_q <= of_en && (t_exp[0] || (rect_trip_q && !sts_clr[`STS_OF_TRIP])); // R1 R3
            exc_stop_q  <= of_en && (t_exp[0] || (rect_trip_q && !sts_clr[`STS_OF_TRIP])); // R3
        end
    end

    // Switch temperature alarm has no enable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            temp_alarm_q <= 1'b0;
        end else if (ce) begin
            temp_alarm_q <= (temp_in > temp_lvl_q); // R7
        end
    end

    // Field breaker trip sequence
    always_comb begin
        st_d = st_q;
        case (st_q)
            BRK_IDLE: begin
                if (int_trip_en && mcc_open && brk_off_cmd) begin
                    st_d = BRK_RUNDOWN; // R8
                end
            end
            BRK_RUNDOWN: begin
                if (t_exp[1]) begin
                    st_d = BRK_TRIP_WAIT; // R8 R11
                end
            end
            BRK_TRIP_WAIT: begin
                if (brk_open) begin
                    st_d = BRK_OPENED;
                end
            end
            BRK_OPENED: begin
                if (!brk_off_cmd) begin
                    st_d = BRK_IDLE;
                end
            end
            default: st_d = BRK_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= BRK_IDLE;
            rundown_q  <= 1'b0;
            brk_trip_q <= 1'b0;
        end else if (ce) begin
            st_q       <= st_d;
            rundown_q  <= (st_d != BRK_IDLE); // R8
            brk_trip_q <= (st_d == BRK_TRIP_WAIT) || (st_d == BRK_OPENED); // R8
        end
    end

    // One event per trip attempt; the sticky copy is cleared by writing one, set wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            brk_fail_evt_q <= 1'b0;
            fail_done_q    <= 1'b0;
            brk_fail_sts_q <= 1'b0;
        end else if (ce) begin
            brk_fail_evt_q <= t_exp[2] && !fail_done_q; // R9
            fail_done_q    <= (st_q == BRK_TRIP_WAIT) && (fail_done_q || t_exp[2]);
            brk_fail_sts_q <= (t_exp[2] && !fail_done_q) ||
                              (brk_fail_sts_q && !sts_clr[`STS_BRK_FAIL]);
        end
    end

    // Open loop ramp; a fraction accumulator keeps slow rates exact
    assign frac_sum = frac_q + {1'b0, ramp_rate_q};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_out_q <= 16'h0000;
            frac_q     <= 17'h00000;
        end else if (ce) begin
            if (!forcing) begin
                ctrl_out_q <= ctrl_in;
                frac_q     <= 17'h00000;
            end else if (tick_q && (ramp_up != ramp_down)) begin
                if (frac_sum >= `RAMP_FRAC_ONE) begin
                    frac_q <= frac_sum - `RAMP_FRAC_ONE; // R12
                    if (ramp_up && ctrl_out_q < `CTRL_MAX) begin
                        ctrl_out_q <= ctrl_out_q + 16'h0001;
                    end else if (ramp_down && ctrl_out_q != 16'h0000) begin
                        ctrl_out_q <= ctrl_out_q - 16'h0001;
                    end
                end else begin
                    frac_q <= frac_sum;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    of_disabled_a: assert property ((ce && !of_en) |=> !rect_trip_q) // R1
        else $error("open field trip while monitoring disabled");

    of_cause_a: assert property ($rose(rect_trip_q) |-> $past(of_en && of_cond, 2)) // R2
        else $error("open field trip without open field condition");

    of_restart_a: assert property ((ce && !of_cond) |=> !t_exp[0]) // R13
        else $error("open field delay kept running after condition cleared");

    temp_alarm_a: assert property ($rose(temp_alarm_q) |-> $past(temp_in > temp_lvl_q)) // R7
        else $error("temperature alarm without excess temperature");

    rundown_start_a: assert property ($rose(rundown_q) |-> // R8
        $past(int_trip_en && mcc_open && brk_off_cmd))
        else $error("run down started without enabled off command");

    trip_after_rundown_a: assert property ($rose(brk_trip_q) |-> $past(rundown_q && !brk_trip_q)) // R11
        else $error("breaker trip without inverter stop phase");

    fail_pulse_a: assert property (brk_fail_evt_q |-> (brk_trip_q && brk_fail_sts_q) ##1 // R9
        !brk_fail_evt_q)
        else $error("breaker fail event not a single pulse during trip");

    ramp_step_a: assert property ((ce && forcing && $past(forcing)) |=> // R12
        ((ctrl_out_q - $past(ctrl_out_q)) == 16'h0000 ||
         (ctrl_out_q - $past(ctrl_out_q)) == 16'h0001 ||
         ($past(ctrl_out_q) - ctrl_out_q) == 16'h0001))
        else $error("forced control signal moved more than one step");

    read_idle_a: assert property ((ce && !rd) |=> rdata_q == 16'h0000)
        else $error("read data present without read strobe");
endmodule : excitation_field_supervision

// File: testbench/brk_partner.sv
// Field breaker model that opens a set number of cycles after its trip command
`timescale 1ns/1ps
module brk_partner (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Breaker side
    input  wire logic        brk_trip_q,
    input  wire logic [15:0] lag,
    output logic             brk_open
);
    logic [15:0] cnt_q;

    // A large lag plays a sticking breaker, a small one a healthy breaker
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q    <= 16'h0000;
            brk_open <= 1'b0;
        end else if (brk_trip_q) begin
            cnt_q    <= cnt_q + 16'h0001;
            brk_open <= (cnt_q >= lag);
        end else begin
            cnt_q    <= 16'h0000;
            brk_open <= 1'b0;
        end
    end
endmodule : brk_partner

// File: testbench/excitation_field_supervision_tb.sv
// Self-checking bench of the field supervision block
`timescale 1ns/1ps
module excitation_field_supervision_tb;
    import exc_sup_pkg::*;
    logic        clk, rst_b, ce, wr, rd, rd_p, ramp_up, ramp_down, mcc_open, brk_off_cmd, brk_open;
    logic        rect_trip_q, exc_stop_q, rundown_q, brk_trip_q, brk_fail_evt_q, temp_alarm_q;
    logic [3:0]  addr;
    word_t       wdata, rdata_q, ctrl_in, ifield_in, temp_in, ctrl_out_q, lag;
    word_t       exp_q[$];
    word_t       rst_tbl[8] = '{16'h0000, 16'h0258, 16'h0064, 16'h000A, 16'h0064, 16'h0005, 16'h000A, 16'h0014};
    int          n_fail, samples_checked, n_evt, i, k, lvl, t;
    logic [31:0] seed;

    excitation_field_supervision #(.TICK_CYCLES(10)) uut (
        .clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
        .ctrl_in(ctrl_in), .ifield_in(ifield_in), .temp_in(temp_in), .ramp_up(ramp_up), .ramp_down(ramp_down),
        .mcc_open(mcc_open), .brk_off_cmd(brk_off_cmd), .brk_open(brk_open), .rect_trip_q(rect_trip_q),
        .exc_stop_q(exc_stop_q), .rundown_q(rundown_q), .brk_trip_q(brk_trip_q),
        .brk_fail_evt_q(brk_fail_evt_q), .temp_alarm_q(temp_alarm_q), .ctrl_out_q(ctrl_out_q)
    );

    brk_partner partner (.clk(clk), .rst_b(rst_b), .brk_trip_q(brk_trip_q), .lag(lag), .brk_open(brk_open));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input word_t e, input word_t g);
        samples_checked++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wreg(input logic [3:0] a, input word_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg

    // The expected word is queued at issue and taken off when the answer stands
    task automatic rreg(input logic [3:0] a, input word_t e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rreg

    function automatic logic pick(input int w);
        case (w)
            0: return rect_trip_q;
            1: return brk_trip_q;
            default: return brk_open;
        endcase
    endfunction : pick

    task automatic wait_for(input int w, input int lim);
        for (int j = 0; j < lim && pick(w) !== 1'b1; j++) @(posedge clk);
        if (pick(w) !== 1'b1) begin
            $display("unexpected wait %0d: expected 1 seen %b", w, pick(w));
            n_fail++;
            stop_test();
        end
    endtask : wait_for

    always @(posedge clk) begin
        if (rd_p) begin
            chk("rdata", exp_q.pop_front(), rdata_q);
        end
        rd_p <= rd;
        if (brk_fail_evt_q === 1'b1) begin
            n_evt++;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        $display("unexpected timeout: expected end seen hang");
        n_fail++;
        stop_test();
    end

    initial begin
        seed = 32'hb96d9843;
        {rst_b, ce, wr, rd, rd_p, ramp_up, ramp_down, mcc_open, brk_off_cmd} = 9'h080;
        {addr, wdata, ctrl_in, ifield_in, temp_in} = '0;
        lag = 16'h0190;
        cyc(10);
        rst_b <= 1'b1;
        for (i = 0; i < 8; i++) rreg(i[3:0], rst_tbl[i]);
        rreg(4'hF, 16'h0000);
        wreg(4'h0, 16'hFFF8);
        rreg(4'h0, 16'h0000);
        // Random levels and temperatures, first pair on the boundary
        for (i = 0; i < 8; i++) begin
            lvl = {$random(seed)} % 201;
            t = (i == 0) ? lvl : {$random(seed)} % 201;
            wreg(4'h4, lvl[15:0]);
            temp_in <= t[15:0];
            cyc(3);
            chk("temp_alarm", t > lvl, temp_alarm_q);
        end
        temp_in <= 16'h0000;
        // Open field with a short delay of 4 ticks
        wreg(4'h1, 16'h0004);
        ctrl_in   <= 16'h0065;
        ifield_in <= 16'h000A;
        cyc(80);
        chk("rect_trip", 1'b0, rect_trip_q);
        wreg(4'h0, 16'h0001);
        cyc(25);
        ifield_in <= 16'h000B;
        cyc(5);
        chk("rect_trip", 1'b0, rect_trip_q);
        ifield_in <= 16'h000A;
        cyc(25);
        chk("rect_trip", 1'b0, rect_trip_q);
        wait_for(0, 30);
        chk("exc_stop", 1'b1, exc_stop_q);
        ctrl_in <= 16'h0000;
        cyc(5);
        chk("rect_trip", 1'b1, rect_trip_q);
        rreg(4'h8, 16'h0001);
        wreg(4'h8, 16'h0001);
        cyc(2);
        chk("rect_trip", 1'b0, rect_trip_q);
        // Breaker sequence: refused with circuit closed, then a sticking and a healthy breaker
        wreg(4'h0, 16'h0002);
        wreg(4'h6, 16'h0001);
        wreg(4'h5, 16'h0001);
        brk_off_cmd <= 1'b1;
        cyc(10);
        chk("rundown", 1'b0, rundown_q);
        for (k = 0; k < 2; k++) begin
            lag         <= k ? 16'h0005 : 16'h0190;
            brk_off_cmd <= 1'b0;
            mcc_open    <= 1'b1;
            cyc(2);
            n_evt = 0;
            brk_off_cmd <= 1'b1;
            cyc(3);
            chk("rundown", 1'b1, rundown_q);
            cyc(180);
            chk("brk_trip", 1'b0, brk_trip_q);
            wait_for(1, 60);
            wait_for(2, 450);
            chk("brk_fail", k ? 0 : 1, n_evt);
            brk_off_cmd <= 1'b0;
            cyc(3);
            chk("rundown", 1'b0, rundown_q);
        end
        // Forced ramp at one control step per tick
        mcc_open <= 1'b0;
        ctrl_in  <= 16'h0032;
        cyc(3);
        wreg(4'h7, 16'h07D0);
        wreg(4'h0, 16'h0004);
        ctrl_in <= 16'h0000;
        ramp_up <= 1'b1;
        cyc(100);
        ramp_up <= 1'b0;
        cyc(2);
        chk("ctrl_up", 1'b1, ctrl_out_q >= 16'h003B && ctrl_out_q <= 16'h003D);
        ramp_down <= 1'b1;
        cyc(100);
        ramp_down <= 1'b0;
        cyc(2);
        chk("ctrl_down", 1'b1, ctrl_out_q >= 16'h0030 && ctrl_out_q <= 16'h0034);
        // Clock enable low freezes the ramp although up is requested
        lvl = ctrl_out_q;
        ce      <= 1'b0;
        ramp_up <= 1'b1;
        cyc(40);
        chk("ctrl_frozen", lvl[15:0], ctrl_out_q);
        ce      <= 1'b1;
        ramp_up <= 1'b0;
        cyc(3);
        stop_test();
    end
endmodule : excitation_field_supervision_tb
